/* rtl/mol_limiter.sv */
// current-squared-time overload limiter with its register port
//
// Overview of operation
// - limiter works only while the closed-loop control bit is one
// - peak current equals rated current times setting in tenths of a percent
// - rated and maximum currents are milliamperes, peak duration is milliseconds
// - active only when peak exceeds rated and duration is nonzero
// - status reads zero when deactivated and one when activated
// - threshold in ampere squared milliseconds selects peak or rated limit
// - accumulated heat value is readable and compared against the threshold
// - present applied current limit is exposed in milliamperes
// - heating limit derives from rated current, peak current and duration
// - peak allowed until heat reaches the limit, then rated at once
// - peak current limit never exceeds the absolute maximum motor current
// - heat grows faster at higher motor current
`include "mol_map.svh"

module mol_limiter
  import mol_pkg::*;
#(
  parameter int STEP_CYCLES = `MOL_STEP_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [15:0] motor_current_ma,
  output logic      [15:0] applied_current_limit_ma,
  output logic             limiter_active
);

  localparam logic [15:0] STEP_LAST = 16'(STEP_CYCLES - 1);

  localparam mol_state_t STATE_RST = '{
    closed_loop : `MOL_RST_CLOSED_LOOP,
    max_ma      : `MOL_RST_MAX_MA,
    rated_ma    : `MOL_RST_RATED_MA,
    peak_set    : `MOL_RST_PEAK_SET,
    dur_ms      : `MOL_RST_DUR_MS,
    step_cnt    : 16'h0000,
    heat        : 48'h0000_0000_0000,
    thresh      : 48'h0000_0000_0000,
    limit_ma    : 16'h0000,
    active      : 1'b0,
    rdata       : 32'h0000_0000
  };

  mol_state_t state_r;
  mol_state_t state_nxt;

  // derived quantities
  logic [31:0] peak_raw;
  logic [15:0] peak_ma;
  logic [31:0] peak_sq;
  logic [31:0] rated_sq;
  logic [31:0] cur_sq;
  logic [47:0] thresh_calc;
  logic        enable;
  logic        step;
  logic [47:0] heat_step;
  logic [47:0] heat_new;
  logic [47:0] heat_a2ms;
  logic [47:0] thresh_a2ms;

  // peak limit, heating limit and activation from the settings
  always_comb begin
    peak_raw    = (32'(state_r.rated_ma) * 32'(state_r.peak_set)) / `MOL_PERMILLE;
    if (peak_raw > {16'h0000, state_r.max_ma}) begin
      peak_ma = state_r.max_ma;
    end else begin
      peak_ma = peak_raw[15:0];
    end
    peak_sq     = 32'(peak_ma) * 32'(peak_ma);
    rated_sq    = 32'(state_r.rated_ma) * 32'(state_r.rated_ma);
    cur_sq      = 32'(motor_current_ma) * 32'(motor_current_ma);
    enable      = state_r.closed_loop && (peak_ma > state_r.rated_ma)
                  && (state_r.dur_ms != 16'h0000);
    // excess heat allowed over the peak duration, in mA^2 ms
    thresh_calc = {16'h0000, peak_sq - rated_sq} * {32'h0000_0000, state_r.dur_ms};
    thresh_a2ms = state_r.thresh / `MOL_MA2_PER_A2;
    heat_a2ms   = state_r.heat / `MOL_MA2_PER_A2;
  end

  // one accumulation step per millisecond
  assign step = (state_r.step_cnt == STEP_LAST);

  // heat accumulation: grows with current squared, decays below rated
  always_comb begin
    heat_step = state_r.heat;
    if (cur_sq >= rated_sq) begin
      heat_step = state_r.heat + {16'h0000, cur_sq - rated_sq};
    end else if (state_r.heat > {16'h0000, rated_sq - cur_sq}) begin
      heat_step = state_r.heat - {16'h0000, rated_sq - cur_sq};
    end else begin
      heat_step = 48'h0000_0000_0000;
    end
    // saturate at the threshold so recovery starts at once
    if (heat_step > thresh_calc) begin
      heat_step = thresh_calc;
    end
    if (!enable) begin
      heat_new = 48'h0000_0000_0000;
    end else if (step) begin
      heat_new = heat_step;
    end else if (state_r.heat > thresh_calc) begin
      heat_new = thresh_calc;
    end else begin
      heat_new = state_r.heat;
    end
  end

  // next state: register writes, limiter update, read data
  always_comb begin
    state_nxt = state_r;
    if (ce) begin
      // step timer
      if (step || !enable) begin
        state_nxt.step_cnt = 16'h0000;
      end else begin
        state_nxt.step_cnt = state_r.step_cnt + 16'h0001;
      end

      // limiter outputs follow the new heat in the same edge
      state_nxt.heat   = heat_new;
      state_nxt.thresh = enable ? thresh_calc : 48'h0000_0000_0000;
      state_nxt.active = enable;
      if (enable && (heat_new >= thresh_calc)) begin
        state_nxt.limit_ma = state_r.rated_ma;
      end else begin
        state_nxt.limit_ma = peak_ma;
      end

      // register writes
      if (reg_wr) begin
        unique case (reg_addr)
          `MOL_OFF_CTRL: begin
            state_nxt.closed_loop = reg_wdata[`MOL_CTRL_CLOSED_LOOP_BIT];
          end
          `MOL_OFF_MAX_MA: begin
            state_nxt.max_ma = reg_wdata[15:0];
          end
          `MOL_OFF_RATED_MA: begin
            state_nxt.rated_ma = reg_wdata[15:0];
          end
          `MOL_OFF_PEAK_SET: begin
            state_nxt.peak_set = reg_wdata[15:0];
          end
          `MOL_OFF_DUR_MS: begin
            state_nxt.dur_ms = reg_wdata[15:0];
          end
          default: begin
            state_nxt.closed_loop = state_r.closed_loop;
          end
        endcase
      end

      // read data stands from the cycle after the strobe until the next enabled cycle
      state_nxt.rdata = 32'h0000_0000;
      if (reg_rd) begin
        unique case (reg_addr)
          `MOL_OFF_CTRL: begin
            state_nxt.rdata[`MOL_CTRL_CLOSED_LOOP_BIT] = state_r.closed_loop;
          end
          `MOL_OFF_MAX_MA: begin
            state_nxt.rdata = {16'h0000, state_r.max_ma};
          end
          `MOL_OFF_RATED_MA: begin
            state_nxt.rdata = {16'h0000, state_r.rated_ma};
          end
          `MOL_OFF_PEAK_SET: begin
            state_nxt.rdata = {16'h0000, state_r.peak_set};
          end
          `MOL_OFF_DUR_MS: begin
            state_nxt.rdata = {16'h0000, state_r.dur_ms};
          end
          `MOL_OFF_THRESH: begin
            state_nxt.rdata = thresh_a2ms[31:0];
          end
          `MOL_OFF_HEAT: begin
            state_nxt.rdata = heat_a2ms[31:0];
          end
          `MOL_OFF_LIMIT: begin
            state_nxt.rdata = {16'h0000, state_r.limit_ma};
          end
          `MOL_OFF_STATUS: begin
            state_nxt.rdata[`MOL_STATUS_ACTIVE_BIT] = state_r.active;
          end
          default: begin
            state_nxt.rdata = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= STATE_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // outputs straight from the state
  assign reg_rdata                = state_r.rdata;
  assign applied_current_limit_ma = state_r.limit_ma;
  assign limiter_active           = state_r.active;

endmodule

/* rtl/mol_map.svh */
// register offsets, reset values and timing figures of the overload limiter
`ifndef MOL_MAP_SVH
`define MOL_MAP_SVH

// register byte offsets
`define MOL_OFF_CTRL      8'h00
`define MOL_OFF_MAX_MA    8'h04
`define MOL_OFF_RATED_MA  8'h08
`define MOL_OFF_PEAK_SET  8'h0C
`define MOL_OFF_DUR_MS    8'h10
`define MOL_OFF_THRESH    8'h14
`define MOL_OFF_HEAT      8'h18
`define MOL_OFF_LIMIT     8'h1C
`define MOL_OFF_STATUS    8'h20

// field positions
`define MOL_CTRL_CLOSED_LOOP_BIT 0
`define MOL_STATUS_ACTIVE_BIT    0

// reset values
`define MOL_RST_CLOSED_LOOP 1'b0
`define MOL_RST_MAX_MA      16'h0000
`define MOL_RST_RATED_MA    16'h0000
`define MOL_RST_PEAK_SET    16'h0000
`define MOL_RST_DUR_MS      16'h0000

// scaling: tenths of a percent, and milliampere squared per ampere squared
`define MOL_PERMILLE        32'h0000_03E8
`define MOL_MA2_PER_A2      48'h0000_000F_4240

// accumulation step time and clock rate
`define MOL_STEP_TIME_US    1000
`define MOL_CLK_MHZ         20
`define MOL_STEP_CYCLES     (`MOL_STEP_TIME_US * `MOL_CLK_MHZ)

`endif

/* rtl/mol_pkg.sv */
// types of the overload limiter
package mol_pkg;

  // whole state of the limiter
  typedef struct packed {
    logic        closed_loop;
    logic [15:0] max_ma;
    logic [15:0] rated_ma;
    logic [15:0] peak_set;
    logic [15:0] dur_ms;
    logic [15:0] step_cnt;
    logic [47:0] heat;
    logic [47:0] thresh;
    logic [15:0] limit_ma;
    logic        active;
    logic [31:0] rdata;
  } mol_state_t;

endpackage

/* verif/mol_limiter_chk.sv */
// port assertions of the overload limiter
module mol_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [15:0] applied_current_limit_ma,
  input wire logic        limiter_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // read port, status and heat views
  a_rdata_idle: assert property ($past(ce && !reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("stray read data");
  a_status_read: assert property ($past(ce && reg_rd && reg_addr == 8'h20) |-> reg_rdata[0] == $past(limiter_active))
    else $error("status read wrong");
  a_limit_read: assert property ($past(ce && reg_rd && reg_addr == 8'h1C) |-> reg_rdata[15:0] == $past(applied_current_limit_ma))
    else $error("limit read wrong");
  a_heat_idle: assert property ($past(ce && reg_rd && reg_addr == 8'h18 && !limiter_active) && $past(!limiter_active, 2) |-> reg_rdata == 32'h0000_0000)
    else $error("heat kept while inactive");
  // activation follows settings only
  a_active_cause: assert property ($changed(limiter_active) |-> $past(reg_wr, 2))
    else $error("status moved without a write");
  a_limit_hold: assert property (!limiter_active && $past(!limiter_active) && !$past(reg_wr) && !$past(reg_wr, 2) |-> $stable(applied_current_limit_ma))
    else $error("inactive limit moved");
  a_ctrl_off: assert property (ce && reg_wr && reg_addr == 8'h00 && !reg_wdata[0] |-> ##2 !limiter_active)
    else $error("active without closed loop");
  a_ce_freeze: assert property (!$past(ce) |-> $stable(applied_current_limit_ma) && $stable(limiter_active))
    else $error("state moved while frozen");
  // main scenarios
  c_active: cover property ($rose(limiter_active));
  c_limit_move: cover property (limiter_active && $changed(applied_current_limit_ma));
  c_freeze: cover property (!ce);
endmodule

bind mol_limiter mol_chk u_chk (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .applied_current_limit_ma(applied_current_limit_ma),
  .limiter_active(limiter_active));

/* verif/mol_motor_model.sv */
// motor current loop model: follows demand, held to the applied limit
module mol_motor_model (
  input  wire logic        clk,
  input  wire logic [15:0] demand_ma,
  input  wire logic [15:0] limit_ma,
  output logic      [15:0] current_ma
);
  timeunit 1ns;
  timeprecision 1ns;
  // current settles to demand, clamped by the limit
  always_ff @(posedge clk) begin
    current_ma <= (demand_ma > limit_ma) ? limit_ma : demand_ma;
  end
endmodule

/* verif/tb_top.sv */
// bench: setting rows, heat build-up and recovery of the limiter
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [15:0] m, r, s, d; logic cl, act; logic [15:0] lim, thr;} mol_row_t;
  logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0, act;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, v;
  logic [15:0] dem = 16'h0000, cur, lim;
  int          err_total = 0, n_checks = 0, t1, t2;
  // max, rated, setting, duration, closed loop -> active, limit, threshold
  mol_row_t rows [5] = '{
    '{16'h0BB8, 16'h03E8, 16'h07D0, 16'h0064, 1'b1, 1'b1, 16'h07D0, 16'h012C},
    '{16'h0BB8, 16'h03E8, 16'h07D0, 16'h0064, 1'b0, 1'b0, 16'h07D0, 16'h0000},
    '{16'h05DC, 16'h03E8, 16'h07D0, 16'h0064, 1'b1, 1'b1, 16'h05DC, 16'h007D},
    '{16'h0BB8, 16'h03E8, 16'h07D0, 16'h0000, 1'b1, 1'b0, 16'h07D0, 16'h0000},
    '{16'h0BB8, 16'h03E8, 16'h03E8, 16'h0064, 1'b1, 1'b0, 16'h03E8, 16'h0000}};
  always #25 clk = ~clk;
  mol_limiter #(.STEP_CYCLES(8)) uut (.clk(clk), .rst(rst), .ce(ce), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .motor_current_ma(cur), .applied_current_limit_ma(lim),
    .limiter_active(act));
  mol_motor_model mdl (.clk(clk), .demand_ma(dem), .limit_ma(lim), .current_ma(cur));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wrr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= {16'h0000, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdd(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  task automatic setup(input logic [15:0] m, r, s, d, input logic cl);
    wrr(8'h04, m);
    wrr(8'h08, r);
    wrr(8'h0C, s);
    wrr(8'h10, d);
    wrr(8'h00, {15'h0000, cl});
    repeat (2) @(posedge clk);
  endtask
  // restart the limiter with a demand and count cycles until the rated clamp
  task automatic heat_run(input logic [15:0] d, output int n);
    wrr(8'h00, 16'h0000);
    wrr(8'h00, 16'h0001);
    dem <= d;
    n = 0;
    while (lim !== 16'h03E8 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n >= 200) begin
      err_total++;
      print_verdict();
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({15'h0000, act, lim}, 32'h0000_0000);
    foreach (rows[i]) begin
      setup(rows[i].m, rows[i].r, rows[i].s, rows[i].d, rows[i].cl);
      chk({31'h0000_0000, act}, {31'h0000_0000, rows[i].act});
      chk({16'h0000, lim}, {16'h0000, rows[i].lim});
      rdd(8'h20);
      chk(v, {31'h0000_0000, rows[i].act});
      rdd(8'h1C);
      chk(v, {16'h0000, rows[i].lim});
      rdd(8'h14);
      if (rows[i].act) chk(v, {16'h0000, rows[i].thr});
    end
    rdd(8'h24);
    chk(v, 32'h0000_0000);
    @(posedge clk);
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    setup(16'h0BB8, 16'h03E8, 16'h07D0, 16'h0002, 1'b1);
    heat_run(16'h07D0, t1);
    chk({31'h0000_0000, t1 >= 9 && t1 <= 26}, 32'h0000_0001);
    rdd(8'h18);
    chk(v, 32'h0000_0006);
    @(posedge clk);
    dem <= 16'h01F4;
    repeat (30) @(negedge clk);
    chk({16'h0000, lim}, 32'h0000_07D0);
    heat_run(16'h05DC, t2);
    chk({31'h0000_0000, t2 > t1 + 16}, 32'h0000_0001);
    print_verdict();
  end
endmodule
